//--- src/psc_pkg.sv
// Purpose: shared constants and carriers for the setpoint compare block
// Assumes: byte-wide process image access, one slot per module
// Notes:   diagnostic byte bits 7..4 read as zero

// ============================================================
// package
package psc_pkg;

	// ============================================================
	// process image layout
	localparam logic [7:0] PSC_IMG_LO     = 8'h40;
	localparam int         PSC_SLOT_SHIFT = 3;
	localparam logic [2:0] PSC_SLOT_MAX   = 3'h7;
	localparam logic [2:0] PSC_IB_RSVD    = 3'h0;
	localparam logic [2:0] PSC_IB_DIAG    = 3'h1;
	localparam logic [2:0] PSC_IB_POS_HI  = 3'h2;
	localparam logic [2:0] PSC_IB_POS_LO  = 3'h3;
	localparam logic [2:0] PSC_QB_SP1_HI  = 3'h0;
	localparam logic [2:0] PSC_QB_SP1_LO  = 3'h1;
	localparam logic [2:0] PSC_QB_SP2_HI  = 3'h2;
	localparam logic [2:0] PSC_QB_SP2_LO  = 3'h3;

	// ============================================================
	// diagnostic byte bits
	localparam int PSC_DIAG_SYNC = 0;
	localparam int PSC_DIAG_S1   = 1;
	localparam int PSC_DIAG_S2   = 2;
	localparam int PSC_DIAG_OVF  = 3;

	// ============================================================
	// value limits and reset values
	localparam logic signed [15:0] PSC_POS_MAX  = 16'sh7fff;
	localparam logic signed [15:0] PSC_POS_MIN  = -16'sh8000;
	localparam logic signed [15:0] PSC_POS_ONE  = 16'sh0001;
	localparam logic signed [15:0] PSC_POS_RST  = 16'sh0000;
	localparam logic [15:0]        PSC_SP_RST   = 16'h0000;
	localparam logic [7:0]         PSC_BYTE_ZERO = 8'h00;

	// ============================================================
	// carriers
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} psc_img_wr_s;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
	} psc_img_rd_s;

	typedef struct packed {
		logic        up;
		logic        dn;
		logic        sync_done;
	} psc_count_s;

endpackage

//--- src/psc_edge.sv
// Purpose: rising and falling edge detect for a group of level inputs
// Assumes: inputs synchronous to mclk_i
// Notes:   edges are combinational from the input and the held level

// ============================================================
// edge detector
module psc_edge
	import psc_pkg::*;
#(
	parameter int W = 2
)
(
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] lvl_i,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);

	typedef struct packed {
		logic [W-1:0] prev;
	} psc_edge_state_s;

	psc_edge_state_s st_r;
	psc_edge_state_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (ce_i)
		begin
			st_nxt.prev = lvl_i;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ============================================================
	// per-bit edges
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			assign rise_o[gi] = lvl_i[gi] & ~st_r.prev[gi];
			assign fall_o[gi] = ~lvl_i[gi] & st_r.prev[gi];
		end
	endgenerate

endmodule

//--- src/psc_top.sv
// Purpose: setpoint compare, overflow and process image slot of a position decoder
// Assumes: count pulses and sync completion come from the decoder front end
// Notes:   all state frozen while ce_i is low

// ============================================================
// top
module psc_top
	import psc_pkg::*;
#(
	parameter logic [2:0] SLOT = 3'h0
)
(
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	input  wire logic        enable_i,
	input  wire logic        plc_run_i,
	input  wire psc_count_s  count_i,
	input  wire psc_img_wr_s output_image_i,
	input  wire psc_img_rd_s input_image_i,
	output logic      [7:0]  rdata_o,
	output logic             rvalid_o,
	output logic             first_out_o,
	output logic             second_out_o,
	output logic      [7:0]  diag_o
);

	// ============================================================
	// state
	typedef struct packed {
		logic signed [15:0] pos;
		logic [15:0]        stg1;
		logic [15:0]        stg2;
		logic [15:0]        eff1;
		logic [15:0]        eff2;
		logic               sync;
		logic               ovf;
		logic               first_match_flag;
		logic               second_match_flag;
		logic               out1;
		logic               out2;
		logic [7:0]         diag;
		logic [7:0]         rdata;
		logic               rvalid;
	} psc_state_s;

	psc_state_s st_r;
	psc_state_s st_nxt;

	// ============================================================
	// slot decode
	localparam logic [7:0] BASE = PSC_IMG_LO + {2'b00, SLOT, 3'b000};

	logic wr_hit;
	logic rd_hit;
	logic [2:0] wr_byte;
	logic [2:0] rd_byte;

	assign wr_hit  = output_image_i.en &&
		(output_image_i.addr[7:PSC_SLOT_SHIFT] == BASE[7:PSC_SLOT_SHIFT]);
	assign rd_hit  = input_image_i.en &&
		(input_image_i.addr[7:PSC_SLOT_SHIFT] == BASE[7:PSC_SLOT_SHIFT]);
	assign wr_byte = output_image_i.addr[2:0];
	assign rd_byte = input_image_i.addr[2:0];

	// ============================================================
	// edges of enable and run
	logic [1:0] lvl;
	logic [1:0] rise;
	logic [1:0] fall;
	logic       en_rise;
	logic       run_fall;

	assign lvl = {plc_run_i, enable_i};

	psc_edge #(
		.W(2)
	) u_edge (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.lvl_i     (lvl),
		.rise_o    (rise),
		.fall_o    (fall)
	);

	assign en_rise  = rise[0];
	assign run_fall = fall[1];

	// ============================================================
	// next state
	logic match1;
	logic match2;
	logic armed;
	logic [15:0] tgt1;
	logic [15:0] tgt2;

	always_comb
	begin
		st_nxt = st_r;
		match1 = 1'b0;
		match2 = 1'b0;
		armed  = 1'b0;
		// the copy into eff lags the flag drop by one cycle, so on the
		// enable rise the staged value is the target, not the old one
		tgt1   = en_rise ? st_r.stg1 : st_r.eff1;
		tgt2   = en_rise ? st_r.stg2 : st_r.eff2;
		if (ce_i)
		begin
			// counting, sync has priority since it reloads the count
			if (count_i.sync_done)
			begin
				st_nxt.pos  = PSC_POS_RST;
				st_nxt.sync = 1'b1;
				st_nxt.ovf  = 1'b0;
			end
			else if (count_i.up && !count_i.dn)
			begin
				if (st_r.pos == PSC_POS_MAX)
				begin
					st_nxt.ovf = 1'b1;
				end
				st_nxt.pos = st_r.pos + PSC_POS_ONE;
			end
			else if (count_i.dn && !count_i.up)
			begin
				if (st_r.pos == PSC_POS_MIN)
				begin
					st_nxt.ovf = 1'b1;
				end
				st_nxt.pos = st_r.pos - PSC_POS_ONE;
			end
			// sync is only ever set; overflow leaves it alone

			// host setpoint writes always land in staging
			if (wr_hit)
			begin
				unique case (wr_byte)
					PSC_QB_SP1_HI: st_nxt.stg1[15:8] = output_image_i.data;
					PSC_QB_SP1_LO: st_nxt.stg1[7:0]  = output_image_i.data;
					PSC_QB_SP2_HI: st_nxt.stg2[15:8] = output_image_i.data;
					PSC_QB_SP2_LO: st_nxt.stg2[7:0]  = output_image_i.data;
					default: ;
				endcase
			end

			// staging passes through only while the reached flag is clear;
			// the flag drops with enable low, so the rise edge finds it clear
			if (!st_r.first_match_flag)
			begin
				st_nxt.eff1 = st_nxt.stg1;
			end
			if (!st_r.second_match_flag)
			begin
				st_nxt.eff2 = st_nxt.stg2;
			end

			// compare against effective setpoints; reset value zero gives
			// the switch-on at position zero if nothing was loaded
			armed  = st_r.sync && !st_r.ovf && enable_i;
			match1 = armed && (st_r.pos == $signed(tgt1));
			match2 = armed && (st_r.pos == $signed(tgt2));
			if (match1)
			begin
				st_nxt.first_match_flag = 1'b1;
				st_nxt.out1             = 1'b1;
			end
			if (match2)
			begin
				st_nxt.second_match_flag = 1'b1;
				st_nxt.out2              = 1'b1;
			end

			// outputs latch; only enable low or run stop drops them
			if (!enable_i)
			begin
				st_nxt.first_match_flag  = 1'b0;
				st_nxt.second_match_flag = 1'b0;
				st_nxt.out1              = 1'b0;
				st_nxt.out2              = 1'b0;
			end
			if (run_fall)
			begin
				// flags follow the outputs so they stay a true on-status
				st_nxt.first_match_flag  = 1'b0;
				st_nxt.second_match_flag = 1'b0;
				st_nxt.out1              = 1'b0;
				st_nxt.out2              = 1'b0;
			end

			// diagnostic byte image
			st_nxt.diag                = PSC_BYTE_ZERO;
			st_nxt.diag[PSC_DIAG_SYNC] = st_nxt.sync;
			st_nxt.diag[PSC_DIAG_S1]   = st_nxt.first_match_flag;
			st_nxt.diag[PSC_DIAG_S2]   = st_nxt.second_match_flag;
			st_nxt.diag[PSC_DIAG_OVF]  = st_nxt.ovf;

			// input image read, answered one cycle later
			st_nxt.rvalid = rd_hit;
			st_nxt.rdata  = PSC_BYTE_ZERO;
			if (rd_hit)
			begin
				unique case (rd_byte)
					PSC_IB_DIAG:   st_nxt.rdata = st_r.diag;
					PSC_IB_POS_HI: st_nxt.rdata = st_r.pos[15:8];
					PSC_IB_POS_LO: st_nxt.rdata = st_r.pos[7:0];
					default:       st_nxt.rdata = PSC_BYTE_ZERO;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ============================================================
	// outputs
	assign rdata_o      = st_r.rdata;
	assign rvalid_o     = st_r.rvalid;
	assign first_out_o  = st_r.out1;
	assign second_out_o = st_r.out2;
	assign diag_o       = st_r.diag;

	// ============================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	sequence seq_armed1;
		ce_i && st_r.sync && !st_r.ovf && enable_i && !run_fall &&
			(st_r.pos == $signed(en_rise ? st_r.stg1 : st_r.eff1));
	endsequence

	sequence seq_out1_on;
		st_r.out1 && st_r.first_match_flag;
	endsequence

	chk_enable_low_clears: assert property (
		(ce_i && !enable_i) |=> (!st_r.out1 && !st_r.out2 &&
			!st_r.first_match_flag && !st_r.second_match_flag))
		else $error("enable low did not clear outputs");

	chk_run_stop_clears: assert property (
		(ce_i && run_fall) |=> (!first_out_o && !second_out_o))
		else $error("run to stop did not clear outputs");

	chk_match_sets_out: assert property (
		seq_armed1 |=> seq_out1_on)
		else $error("setpoint 1 match did not set output");

	chk_set_has_cause: assert property (
		$rose(st_r.out1) |-> ($past(st_r.sync) && !$past(st_r.ovf) && $past(enable_i)))
		else $error("output 1 set without its conditions");

	chk_output_holds: assert property (
		(st_r.out1 && ce_i && enable_i && !run_fall) |=> st_r.out1)
		else $error("output 1 dropped while enabled");

	chk_overflow_sets: assert property (
		(ce_i && count_i.up && !count_i.dn && !count_i.sync_done &&
			st_r.pos == PSC_POS_MAX) |=> (st_r.ovf && st_r.pos == PSC_POS_MIN))
		else $error("overflow at top of range not flagged");

	chk_sync_sticky: assert property (
		st_r.sync |=> st_r.sync)
		else $error("sync flag cleared");

	chk_sync_clears_ovf: assert property (
		(ce_i && count_i.sync_done) |=> (!st_r.ovf && st_r.sync && st_r.pos == PSC_POS_RST))
		else $error("sync did not clear overflow");

	chk_sp_immediate: assert property (
		(ce_i && !st_r.first_match_flag && !wr_hit) |=> (st_r.eff1 == st_r.stg1))
		else $error("setpoint 1 not effective while flag clear");

	chk_sp_held: assert property (
		(ce_i && st_r.first_match_flag) |=> (st_r.eff1 == $past(st_r.eff1)))
		else $error("setpoint 1 changed while reached");

	chk_count_step: assert property (
		(ce_i && count_i.dn && !count_i.up && !count_i.sync_done &&
			st_r.pos != PSC_POS_MIN) |=> (st_r.pos == $past(st_r.pos) - PSC_POS_ONE))
		else $error("down pulse did not decrement position");

	chk_diag_read: assert property (
		(ce_i && rd_hit && rd_byte == PSC_IB_DIAG) |=>
			(rvalid_o && rdata_o == $past(st_r.diag)))
		else $error("diagnostic byte read mismatch");

	chk_diag_map: assert property (
		(diag_o[PSC_DIAG_S1] == st_r.first_match_flag) &&
		(diag_o[PSC_DIAG_S2] == st_r.second_match_flag) &&
		(diag_o[PSC_DIAG_OVF] == st_r.ovf))
		else $error("diagnostic byte bits misplaced");

	chk_foreign_slot: assert property (
		(ce_i && input_image_i.en && !rd_hit) |=> !rvalid_o)
		else $error("read answered outside own slot");

	chk_rise_new_sp: assert property (
		(ce_i && en_rise && (st_r.pos != $signed(st_r.stg1))) |=> !st_r.out1)
		else $error("old setpoint 1 switched after enable rise");

	chk_ovf_blocks_out1: assert property (
		(ce_i && st_r.ovf && !st_r.out1) |=> !st_r.out1)
		else $error("output 1 switched on during overflow");

	chk_ovf_blocks_out2: assert property (
		(ce_i && st_r.ovf && !st_r.out2) |=> !st_r.out2)
		else $error("output 2 switched on during overflow");

endmodule

//--- bench/psc_host_model.sv
// Purpose: host controller side of the process image slot
// Assumes: one byte access at a time, requests launched 1 ns after mclk_i
// Notes:   released address and data lines show inverted values

// ============================================================
// host model
module psc_host_model
	import psc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic [7:0]  rdata_i,
	input  wire logic        rvalid_i,
	output psc_img_wr_s      output_image_o,
	output psc_img_rd_s      input_image_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		output_image_o = '{1'b0, 8'h00, 8'h00};
		input_image_o  = '{1'b0, 8'h00};
	end

	// byte write, held for one taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		output_image_o = '{1'b1, a, d};
		@(posedge mclk_i);
		#1;
		output_image_o = '{1'b0, ~a, ~d};
	endtask

	// byte read, answer sampled 1 ns after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge mclk_i);
		#1;
		input_image_o = '{1'b1, a};
		@(posedge mclk_i);
		#1;
		v = rvalid_i;
		d = rdata_i;
		input_image_o = '{1'b0, ~a};
	endtask

	// setpoint word, high byte at the lower address
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 8'h01, v[7:0]);
	endtask
endmodule

//--- bench/test_position_setpoint_compare.sv
// Purpose: self-checking bench for the setpoint compare block
// Assumes: ce_i high except in the freeze check; count pulses made by the bench
// Notes:   non-zero slot so the slot decode is exercised

// ============================================================
// bench top
module test_position_setpoint_compare
	import psc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [2:0] SLOT = 3'h5;
	localparam logic [7:0] BASE = PSC_IMG_LO + (8'(SLOT) << PSC_SLOT_SHIFT);

	logic        mclk_i;
	logic        sys_rst_i;
	logic        ce_i;
	logic        enable_i;
	logic        plc_run_i;
	psc_count_s  count_i;
	psc_img_wr_s output_image_i;
	psc_img_rd_s input_image_i;
	logic [7:0]  rdata_o;
	logic        rvalid_o;
	logic        first_out_o;
	logic        second_out_o;
	logic [7:0]  diag_o;
	int          bad_count;
	int          check_count;
	int          cyc;
	logic [7:0]  rb;
	logic        rv;

	psc_top #(.SLOT(SLOT)) psc_top_inst (
		.mclk_i         (mclk_i),
		.sys_rst_i      (sys_rst_i),
		.ce_i           (ce_i),
		.enable_i       (enable_i),
		.plc_run_i      (plc_run_i),
		.count_i        (count_i),
		.output_image_i (output_image_i),
		.input_image_i  (input_image_i),
		.rdata_o        (rdata_o),
		.rvalid_o       (rvalid_o),
		.first_out_o    (first_out_o),
		.second_out_o   (second_out_o),
		.diag_o         (diag_o)
	);

	psc_host_model psc_host_model_inst (
		.mclk_i         (mclk_i),
		.rdata_i        (rdata_o),
		.rvalid_i       (rvalid_o),
		.output_image_o (output_image_i),
		.input_image_o  (input_image_i)
	);

	// ============================================================
	// clock and timeout
	initial
	begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// full overflow walk is about 33k cycles
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			bad_count++;
			end_sim();
		end
	end

	// ============================================================
	// compare and drive tasks
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_outs(input logic o1, input logic o2, input logic [7:0] dg);
		chk_bit("first_out_o", o1, first_out_o);
		chk_bit("second_out_o", o2, second_out_o);
		chk_byte("diag_o", dg, diag_o);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		psc_host_model_inst.rd(a, rb, rv);
		chk_bit("rvalid_o", 1'b1, rv);
		chk_byte(what, exp, rb);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// n consecutive one-cycle count pulses
	task automatic cnt(input logic up, input logic dn, input logic sy, input int n);
		@(posedge mclk_i);
		#1;
		count_i = '{up, dn, sy};
		repeat (n) @(posedge mclk_i);
		#1;
		count_i = '{1'b0, 1'b0, 1'b0};
	endtask

	task automatic set_en(input logic v);
		@(posedge mclk_i);
		#1;
		enable_i = v;
	endtask

	task automatic end_sim();
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ============================================================
	// main sequence
	initial
	begin
		sys_rst_i = 1'b1;
		ce_i      = 1'b1;
		enable_i  = 1'b0;
		plc_run_i = 1'b1;
		count_i   = '{1'b0, 1'b0, 1'b0};
		repeat (4) @(posedge mclk_i);
		#1;
		sys_rst_i = 1'b0;
		wait_cyc(1);
		chk_outs(1'b0, 1'b0, 8'h00);
		rd_chk(BASE + 8'h01, 8'h00, "diag byte");
		rd_chk(BASE + 8'h04, 8'h00, "unused byte");
		psc_host_model_inst.rd(BASE + 8'h08, rb, rv);
		chk_bit("foreign slot rvalid", 1'b0, rv);
		// enable before sync must not switch
		set_en(1'b1);
		wait_cyc(3);
		chk_outs(1'b0, 1'b0, 8'h00);
		cnt(1'b0, 1'b0, 1'b1, 1);
		wait_cyc(2);
		chk_outs(1'b1, 1'b1, 8'h07);
		rd_chk(BASE + 8'h01, 8'h07, "sync bit");
		// new setpoint held off while output on
		psc_host_model_inst.wr16(BASE + PSC_QB_SP1_HI, 16'h0003);
		cnt(1'b1, 1'b0, 1'b0, 3);
		wait_cyc(2);
		chk_outs(1'b1, 1'b1, 8'h07);
		set_en(1'b0);
		wait_cyc(2);
		chk_outs(1'b0, 1'b0, 8'h01);
		set_en(1'b1);
		wait_cyc(2);
		chk_outs(1'b1, 1'b0, 8'h03);
		rd_chk(BASE + 8'h02, 8'h00, "pos hi");
		rd_chk(BASE + 8'h03, 8'h03, "pos lo");
		// flag clear: immediate take-over, match going down
		psc_host_model_inst.wr16(BASE + PSC_QB_SP2_HI, 16'hfffe);
		cnt(1'b0, 1'b1, 1'b0, 5);
		wait_cyc(2);
		chk_outs(1'b1, 1'b1, 8'h07);
		rd_chk(BASE + 8'h02, 8'hff, "neg pos hi");
		rd_chk(BASE + 8'h03, 8'hfe, "neg pos lo");
		plc_run_i = 1'b0;
		wait_cyc(1);
		chk_bit("first_out_o at stop", 1'b0, first_out_o);
		chk_bit("second_out_o at stop", 1'b0, second_out_o);
		enable_i  = 1'b0;
		plc_run_i = 1'b1;
		// overflow walk from -2 to past 32767
		psc_host_model_inst.wr16(BASE + PSC_QB_SP1_HI, 16'h7fff);
		psc_host_model_inst.wr16(BASE + PSC_QB_SP2_HI, 16'h0001);
		set_en(1'b1);
		cnt(1'b1, 1'b0, 1'b0, 32769);
		wait_cyc(2);
		chk_outs(1'b1, 1'b1, 8'h07);
		cnt(1'b1, 1'b0, 1'b0, 1);
		wait_cyc(2);
		chk_outs(1'b1, 1'b1, 8'h0f);
		rd_chk(BASE + 8'h02, 8'h80, "wrap pos hi");
		set_en(1'b0);
		wait_cyc(2);
		chk_outs(1'b0, 1'b0, 8'h09);
		set_en(1'b1);
		psc_host_model_inst.wr16(BASE + PSC_QB_SP1_HI, 16'h8000);
		wait_cyc(2);
		chk_outs(1'b0, 1'b0, 8'h09);
		cnt(1'b0, 1'b0, 1'b1, 1);
		wait_cyc(2);
		chk_outs(1'b0, 1'b0, 8'h01);
		cnt(1'b1, 1'b0, 1'b0, 1);
		wait_cyc(2);
		chk_outs(1'b0, 1'b1, 8'h05);
		// one-cycle enable drop: the old setpoint must not switch again
		psc_host_model_inst.wr16(BASE + PSC_QB_SP2_HI, 16'h0005);
		set_en(1'b0);
		set_en(1'b1);
		wait_cyc(2);
		chk_outs(1'b0, 1'b0, 8'h01);
		cnt(1'b1, 1'b0, 1'b0, 4);
		wait_cyc(2);
		chk_outs(1'b0, 1'b1, 8'h05);
		// clock enable low freezes the count
		ce_i = 1'b0;
		cnt(1'b1, 1'b0, 1'b0, 2);
		ce_i = 1'b1;
		rd_chk(BASE + 8'h03, 8'h05, "frozen pos lo");
		end_sim();
	end
endmodule
